/* File: pkg/ftx_pkg.sv */
package ftx_pkg;

  // Code-group width and nibble width
  localparam int unsigned SYM_W    = 5;
  localparam int unsigned NIB_W    = 4;
  localparam logic [2:0]  SYM_BITS = 3'h5;

  // Control code-groups
  localparam logic [4:0] SYM_IDLE  = 5'h1F;
  localparam logic [4:0] SYM_SSD1  = 5'h18;
  localparam logic [4:0] SYM_SSD2  = 5'h11;
  localparam logic [4:0] SYM_ESD1  = 5'h0D;
  localparam logic [4:0] SYM_ESD2  = 5'h07;
  localparam logic [4:0] SYM_HALT  = 5'h04;

  // Nibble equivalents of control code-groups
  localparam logic [3:0] NIB_IDLE_END = 4'h0;
  localparam logic [3:0] NIB_START    = 4'h5;

  // Scrambler: 11 stages, taps at stages 11 and 9
  localparam int unsigned LFSR_W      = 11;
  localparam int unsigned LFSR_TAP_HI = 10;
  localparam int unsigned LFSR_TAP_LO = 8;
  localparam logic [10:0] LFSR_RST    = 11'h7FF;
  localparam logic [5:0]  SEED_LO     = 6'h2B;

  // Strap settle count after reset release
  localparam logic [1:0]  SEED_WAIT   = 2'h3;

  // Line phases driving the two sides of the driver
  localparam logic [1:0]  PH_POS      = 2'h1;
  localparam logic [1:0]  PH_NEG      = 2'h3;

  // Buffer entry: {err, en, nibble}
  localparam int unsigned ENT_W       = 6;

  function automatic logic [4:0] ftx_enc_4b5b(input logic [3:0] nib);
    logic [4:0] s;
    s = SYM_IDLE;
    case (nib)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      4'hF: s = 5'h1D;
      default: s = SYM_IDLE;
    endcase
    return s;
  endfunction

  function automatic logic [3:0] ftx_ctrl_nibble(input logic [4:0] sym, input logic [3:0] dflt);
    logic [3:0] n;
    n = dflt;
    if (sym == SYM_SSD1 || sym == SYM_SSD2) begin
      n = NIB_START;
    end else if (sym == SYM_IDLE || sym == SYM_ESD1 || sym == SYM_ESD2) begin
      n = NIB_IDLE_END;
    end
    return n;
  endfunction

endpackage

/* File: design/ftx_buf2.sv */
`timescale 1ns/1ns
module ftx_buf2 #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wptr;
    logic                  rptr;
    logic [1:0]            cnt;
  } ftx_buf_t;

  ftx_buf_t s_q;
  ftx_buf_t s_d;
  logic     push;
  logic     pop;

  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr          = ~s_q.wptr;
    end
    if (pop) begin
      s_d.rptr = ~s_q.rptr;
    end
    case ({push, pop})
      2'b10:   s_d.cnt = s_q.cnt + 2'h1;
      2'b01:   s_d.cnt = s_q.cnt - 2'h1;
      default: s_d.cnt = s_q.cnt;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: design/ftx_coder.sv */
`timescale 1ns/1ns
// Functional notes
// [RULE1] Nibbles from the MAC become a scrambled three-level serial stream.
// [RULE2] Data nibbles map to their fixed sixteen 5-bit code-groups.
// [RULE3] First two preamble nibbles are replaced by start pair 11000, 10001.
// [RULE4] Later preamble and data nibbles encode one for one.
// [RULE5] On transmit-enable drop, end pair 01101 then 00111 follows.
// [RULE6] Idle 11111 is sent continuously until the next frame starts.
// [RULE7] Idle and end symbols equal nibble 0000; start symbols equal 0101.
// [RULE8] Code-group 00100 is the halt error symbol, never a data value.
// [RULE9] Scrambler is a closed-loop 11-stage linear feedback shift register.
// [RULE10] Scrambler output is XORed bitwise with the serial code-group stream.
// [RULE11] Scrambler seed comes from the five address strap inputs.
// [RULE12] Scrambled serial stream is NRZI encoded before three-level conversion.
// [RULE13] Three-level stage splits into two streams with alternating one events.
// [RULE14] Outputs carry only three-level symbols; no plain binary mode.
// [RULE15] Encoder stage and scrambler stage each have a bypass option.
// [RULE16] Device supplies the nibble transmit clock to the MAC.
// [RULE17] MAC presents nibble and enable synchronous to that clock.
// [RULE18] Each code-group is sent five bits per nibble period, first bit leftmost.
// [RULE19] NRZI toggles on each one and holds on each zero.
// [RULE20] The ten unused 5-bit patterns are never produced by the encoder.
module ftx_coder
  import ftx_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       link_clk,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  input  wire logic [4:0] address_strap_inputs,
  input  wire logic       enc_bypass,
  input  wire logic       scr_bypass,
  output logic            tx_clk,
  output logic            tx_line_pair_pos,
  output logic            tx_line_pair_neg,
  output logic            line_bit_stb,
  output logic [4:0]      code_group,
  output logic [3:0]      code_nibble,
  output logic [4:0]      strapped_station_id,
  output logic            buf_in_ready
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SSD2 = 4'b0010,
    ST_DATA = 4'b0100,
    ST_ESD2 = 4'b1000
  } ftx_state_t;

  typedef struct packed {
    logic              clk_s1;
    logic              clk_s2;
    logic              clk_s3;
    logic [ENT_W-1:0]  dat_s1;
    logic [ENT_W-1:0]  dat_s2;
    logic [4:0]        strap_s1;
    logic [4:0]        strap_s2;
    logic [4:0]        station_id;
    logic [1:0]        seed_cnt;
    logic              seeded;
    logic              clk_out;
    ftx_state_t        st;
    logic [4:0]        shreg;
    logic [2:0]        bitcnt;
    logic [LFSR_W-1:0] lfsr;
    logic              nrzi;
    logic [1:0]        phase;
    logic              line_pos;
    logic              line_neg;
    logic              bit_stb;
    logic [4:0]        cur_sym;
    logic [3:0]        cur_nib;
  } ftx_core_t;

  ftx_core_t        s_q;
  ftx_core_t        s_d;

  logic             cap_fall;
  logic             buf_out_valid;
  logic             buf_out_ready;
  logic [ENT_W-1:0] buf_out_data;
  logic             ent_err;
  logic             ent_en;
  logic [3:0]       ent_nib;

  // Mid-period capture: data is stable a half period after the rise
  assign cap_fall = s_q.seeded & s_q.clk_s3 & ~s_q.clk_s2;

  // Serializer asks for a new entry once the last symbol has gone out
  assign buf_out_ready = s_q.seeded & (s_q.bitcnt == 3'h0);

  assign ent_err = buf_out_data[5];
  assign ent_en  = buf_out_data[4];
  assign ent_nib = buf_out_data[3:0];

  ftx_buf2 #(
    .WIDTH (ENT_W)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (cap_fall),
    .in_ready  (buf_in_ready),
    .in_data   (s_q.dat_s2),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  always_comb begin
    logic [4:0] sym;
    logic       take;
    logic       nbit;
    logic       key;
    logic       scr;
    logic [1:0] ph;
    sym  = SYM_IDLE;
    take = buf_out_valid & buf_out_ready;
    nbit = 1'b0;
    key  = 1'b0;
    scr  = 1'b0;
    ph   = s_q.phase;
    s_d  = s_q;

    // Two-stage synchronisers for pins from outside this clock
    s_d.clk_s1   = link_clk;
    s_d.clk_s2   = s_q.clk_s1;
    s_d.clk_s3   = s_q.clk_s2;
    s_d.dat_s1   = {tx_er, tx_en, txd};
    s_d.dat_s2   = s_q.dat_s1;
    s_d.strap_s1 = address_strap_inputs;
    s_d.strap_s2 = s_q.strap_s1;

    // [RULE16] forward nibble clock
    s_d.clk_out = s_q.clk_s2;

    // [RULE11] seed from address straps
    if (!s_q.seeded) begin
      if (s_q.seed_cnt == SEED_WAIT) begin
        s_d.seeded     = 1'b1;
        s_d.station_id = s_q.strap_s2;
        s_d.lfsr       = {s_q.strap_s2, SEED_LO};
      end else begin
        s_d.seed_cnt = s_q.seed_cnt + 2'h1;
      end
    end

    s_d.bit_stb = 1'b0;

    if (take) begin
      if (enc_bypass) begin
        // [RULE15] encoder bypass passes raw bits
        sym      = {ent_err, ent_nib};
        s_d.st   = ST_IDLE;
      end else begin
        case (s_q.st)
          ST_IDLE: begin
            if (ent_en) begin
              // [RULE3] first start symbol
              sym    = SYM_SSD1;
              s_d.st = ST_SSD2;
            end else begin
              // [RULE6] idle fill
              sym    = SYM_IDLE;
            end
          end
          ST_SSD2: begin
            // [RULE3] second start symbol
            sym    = SYM_SSD2;
            s_d.st = ST_DATA;
          end
          ST_DATA: begin
            if (!ent_en) begin
              // [RULE5] first end symbol
              sym    = SYM_ESD1;
              s_d.st = ST_ESD2;
            end else if (ent_err) begin
              // [RULE8] halt on MAC error
              sym    = SYM_HALT;
            end else begin
              // [RULE2] [RULE4] [RULE20] table only
              sym    = ftx_enc_4b5b(ent_nib);
            end
          end
          ST_ESD2: begin
            // [RULE5] second end symbol
            sym    = SYM_ESD2;
            s_d.st = ST_IDLE;
          end
          default: begin
            sym    = SYM_IDLE;
            s_d.st = ST_IDLE;
          end
        endcase
      end
      s_d.shreg   = sym;
      s_d.bitcnt  = SYM_BITS;
      s_d.cur_sym = sym;
      // [RULE7] nibble equivalents
      s_d.cur_nib = ftx_ctrl_nibble(sym, ent_nib);
    end else if (s_q.bitcnt != 3'h0) begin
      // [RULE18] leftmost bit first
      nbit       = s_q.shreg[4];
      s_d.shreg  = {s_q.shreg[3:0], 1'b0};
      s_d.bitcnt = s_q.bitcnt - 3'h1;

      // [RULE9] closed-loop 11-stage shift
      key      = s_q.lfsr[LFSR_TAP_HI] ^ s_q.lfsr[LFSR_TAP_LO];
      s_d.lfsr = {s_q.lfsr[LFSR_W-2:0], key};

      // [RULE10] [RULE15] XOR or bypass
      scr = scr_bypass ? nbit : (nbit ^ key);

      // [RULE12] [RULE19] NRZI toggle on one
      s_d.nrzi = s_q.nrzi ^ scr;

      // [RULE13] one events alternate sides
      if (s_d.nrzi != s_q.nrzi) begin
        ph = s_q.phase + 2'h1;
      end
      s_d.phase = ph;

      // [RULE1] [RULE14] three-level only
      s_d.line_pos = (ph == PH_POS);
      s_d.line_neg = (ph == PH_NEG);
      s_d.bit_stb  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.lfsr     <= LFSR_RST;
      s_q.shreg    <= SYM_IDLE;
      s_q.cur_sym  <= SYM_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tx_clk              = s_q.clk_out;
  assign tx_line_pair_pos    = s_q.line_pos;
  assign tx_line_pair_neg    = s_q.line_neg;
  assign line_bit_stb        = s_q.bit_stb;
  assign code_group          = s_q.cur_sym;
  assign code_nibble         = s_q.cur_nib;
  assign strapped_station_id = s_q.station_id;

endmodule

/* File: verification/ftx_coder_properties.sv */
`timescale 1ns/1ns
module ftx_coder_properties
  import ftx_pkg::*;
(
  input logic       clk_sys,
  input logic       rst_b,
  input logic       link_clk,
  input logic       enc_bypass,
  input logic       tx_clk,
  input logic       tx_line_pair_pos,
  input logic       tx_line_pair_neg,
  input logic       line_bit_stb,
  input logic [4:0] code_group,
  input logic [3:0] code_nibble
);
  // Ten unused patterns, one bit each
  localparam logic [31:0] BAD = 32'h0201116F;
  logic last_pos_q;
  logic last_pos_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always_comb begin
    last_pos_d = last_pos_q;
    if (tx_line_pair_pos) begin
      last_pos_d = 1'b1;
    end else if (tx_line_pair_neg) begin
      last_pos_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_pos_q <= 1'b0;
    end else begin
      last_pos_q <= last_pos_d;
    end
  end
  sequence five_bits;
    line_bit_stb [*5] ##1 !line_bit_stb;
  endsequence
  burst_len_a: assert property ($rose(line_bit_stb) |-> five_bits)
    else $error("serial burst not five bits");
  // First serial bit follows the symbol load by one cycle
  load_burst_a: assert property ($changed(code_group) |=> line_bit_stb)
    else $error("symbol load without serial bit");
  line_excl_a: assert property (!(tx_line_pair_pos && tx_line_pair_neg))
    else $error("both line sides active");
  line_on_bit_a: assert property ($changed({tx_line_pair_pos, tx_line_pair_neg}) |-> line_bit_stb)
    else $error("line moved between bits");
  pos_alt_a: assert property ($rose(tx_line_pair_pos) |-> !last_pos_q)
    else $error("two positive events in a row");
  neg_alt_a: assert property ($rose(tx_line_pair_neg) |-> last_pos_q)
    else $error("two negative events in a row");
  clk_fwd_a: assert property ($rose(link_clk) |-> ##[2:4] $rose(tx_clk))
    else $error("transmit clock not forwarded");
  ctrl_nib_a: assert property (code_group inside {5'h1F, 5'h0D, 5'h07} |-> code_nibble == 4'h0)
    else $error("idle or end nibble wrong");
  start_nib_a: assert property (code_group inside {5'h18, 5'h11} |-> code_nibble == 4'h5)
    else $error("start nibble wrong");
  no_invalid_a: assert property (!enc_bypass && !$past(enc_bypass) && !$past(enc_bypass, 2)
    && $changed(code_group) |-> !BAD[code_group])
    else $error("invalid code-group emitted");
endmodule

/* File: verification/ftx_mac_model.sv */
`timescale 1ns/1ns
module ftx_mac_model (
  input  logic       clk_sys,
  input  logic       rst_b,
  input  logic       go,
  input  logic [4:0] len,
  input  logic [3:0] base,
  input  logic [4:0] err_at,
  output logic       link_clk,
  output logic [3:0] txd,
  output logic       tx_en,
  output logic       tx_er
);
  logic [1:0] div;
  logic [4:0] pend;
  logic [4:0] idx;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div      <= 2'h0;
      link_clk <= 1'b0;
      pend     <= 5'h00;
      idx      <= 5'h00;
      txd      <= 4'h0;
      tx_en    <= 1'b0;
      tx_er    <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (go) begin
        pend <= len;
      end
      if (div == 2'h3) begin
        link_clk <= ~link_clk;
      end
      if (div == 2'h3 && !link_clk) begin
        if (pend != 5'h00) begin
          tx_en <= 1'b1;
          tx_er <= (idx == err_at);
          txd   <= base + idx[3:0];
          idx   <= idx + 5'h01;
          pend  <= pend - 5'h01;
        end else begin
          tx_en <= 1'b0;
          tx_er <= 1'b0;
          // Idle data lines keep moving
          txd   <= ~txd;
          idx   <= 5'h00;
        end
      end
    end
  end
endmodule

/* File: verification/test_fast_ethernet_tx_coder.sv */
`timescale 1ns/1ns
module test_fast_ethernet_tx_coder
  import ftx_pkg::*;
;
  // Data code-groups, entry 15 first
  localparam logic [15:0][4:0] ENC = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
                                      5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic enc_bypass = 1'b0;
  logic scr_bypass = 1'b0;
  logic byp_p = 1'b0;
  logic go = 1'b0;
  logic [4:0] strap = 5'h00;
  logic [4:0] len = 5'h00;
  logic [3:0] base = 4'h0;
  logic [4:0] err_at = 5'h00;
  logic link_clk, tx_en, tx_er, tx_clk, pos, neg, stb, rdy;
  logic [3:0] txd, nib;
  logic [4:0] code_group, sid, sh;
  logic [10:0] lf;
  logic [1:0] pv;
  logic [4:0] q[$];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int k = 0;
  always #20 clk_sys = ~clk_sys;
  ftx_mac_model mac_u (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .len(len), .base(base), .err_at(err_at),
    .link_clk(link_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er));
  ftx_coder dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .link_clk(link_clk), .txd(txd), .tx_en(tx_en),
    .tx_er(tx_er), .address_strap_inputs(strap), .enc_bypass(enc_bypass), .scr_bypass(scr_bypass),
    .tx_clk(tx_clk), .tx_line_pair_pos(pos), .tx_line_pair_neg(neg), .line_bit_stb(stb),
    .code_group(code_group), .code_nibble(nib), .strapped_station_id(sid), .buf_in_ready(rdy));
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Line decoder: level change, descramble, five bits per symbol
  always @(posedge clk_sys) begin
    cyc++;
    if (rst_b && stb) begin
      sh = {sh[3:0], ({pos, neg} != pv) ^ ((lf[10] ^ lf[8]) & ~byp_p)};
      pv = {pos, neg};
      lf = {lf[9:0], lf[10] ^ lf[8]};
      k++;
      if (k == 5) begin
        k = 0;
        q.push_back(sh);
        chk(sh, code_group);
      end
    end
    byp_p = scr_bypass;
    if (cyc > 5000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic t_reset(input logic [4:0] s);
    rst_b <= 1'b0;
    strap <= s;
    enc_bypass <= 1'b0;
    scr_bypass <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(code_group, 5'h1F);
    chk({3'h0, pos, neg, rdy}, 5'h01);
    lf = {s, SEED_LO};
    pv = 2'h0;
    k = 0;
    rst_b <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk(sid, s);
    $display("reset test done");
  endtask
  task automatic t_frame(input logic [4:0] n, input logic [3:0] b, input logic [4:0] e, input logic eb);
    logic [4:0] x[$];
    int i;
    int j;
    enc_bypass <= eb;
    len <= n;
    base <= b;
    err_at <= e;
    go <= 1'b1;
    q.delete();
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (8 * n + 100) @(posedge clk_sys);
    for (i = 0; i < n; i++) begin
      if (eb) x.push_back({1'b0, b + i[3:0]});
      else if (i < 2) x.push_back(i == 1 ? 5'h11 : 5'h18);
      else x.push_back(i == e ? 5'h04 : ENC[b + i[3:0]]);
    end
    if (!eb) begin
      x.push_back(5'h0D);
      x.push_back(5'h07);
      x.push_back(5'h1F);
      x.push_back(5'h1F);
    end
    j = 0;
    while (j + 1 < q.size() && (q[j] !== x[0] || q[j + 1] !== x[1])) j++;
    for (i = 0; i < x.size(); i++) chk(j + i < q.size() ? q[j + i] : 5'h00, x[i]);
    $display("frame test done");
  endtask
  // Eighteen nibbles, data wraps past the last table entry
  task automatic t_long_frame;
    t_frame(5'h12, 4'h0, 5'h1F, 1'b0);
  endtask
  // MAC error on the fifth nibble gives halt
  task automatic t_halt_frame;
    t_frame(5'h06, 4'h3, 5'h04, 1'b0);
  endtask
  // Scrambler bypassed, left on for the next scenario
  task automatic t_scr_bypass;
    scr_bypass <= 1'b1;
    t_frame(5'h07, 4'h9, 5'h1F, 1'b0);
  endtask
  // Encoder bypassed: raw nibbles, no delimiters
  task automatic t_enc_bypass;
    t_frame(5'h05, 4'h6, 5'h1F, 1'b1);
  endtask
  // Shortest frame: delimiters and two data nibbles
  task automatic t_short_frame;
    t_frame(5'h04, 4'hC, 5'h1F, 1'b0);
  endtask
  initial begin
    t_reset(5'h15);
    t_long_frame();
    t_halt_frame();
    t_scr_bypass();
    t_enc_bypass();
    t_reset(5'h0A);
    t_short_frame();
    end_sim;
  end
endmodule
bind ftx_coder ftx_coder_properties chk_u (.*);
